// File: inc/gpp_pkg.sv
// Register map and constants for the GPIO port block
`default_nettype none
package gpp_pkg;
  localparam int unsigned GPP_PINS = 32;
  localparam logic [7:0] OFF_AF_SEL     = 8'h00;
  localparam logic [7:0] OFF_AF_SET     = 8'h04;
  localparam logic [7:0] OFF_AF_CLR     = 8'h08;
  localparam logic [7:0] OFF_OE         = 8'h0C;
  localparam logic [7:0] OFF_OE_SET     = 8'h10;
  localparam logic [7:0] OFF_OE_CLR     = 8'h14;
  localparam logic [7:0] OFF_OUT        = 8'h18;
  localparam logic [7:0] OFF_OUT_SET    = 8'h1C;
  localparam logic [7:0] OFF_OUT_CLR    = 8'h20;
  localparam logic [7:0] OFF_IN         = 8'h24;
  localparam logic [7:0] OFF_MODE       = 8'h28;
  localparam logic [7:0] OFF_POL        = 8'h2C;
  localparam logic [7:0] OFF_INCON      = 8'h30;
  localparam logic [7:0] OFF_IE         = 8'h34;
  localparam logic [7:0] OFF_IE_SET     = 8'h38;
  localparam logic [7:0] OFF_IE_CLR     = 8'h3C;
  localparam logic [7:0] OFF_PEND       = 8'h40;
  localparam logic [7:0] OFF_PEND_CLR   = 8'h48;
  localparam logic [7:0] OFF_WAKE       = 8'h4C;
  localparam logic [31:0] RST_AF_SEL    = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_INCON     = 32'h0000_0303;
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : gpp_pkg
`default_nettype wire

// File: inc/gpp_evt_if.sv
// Interface carrying detection configuration and events between modules
`default_nettype none
interface gpp_evt_if #(parameter int unsigned W = 32);
  logic [W-1:0] pin_sync;
  logic [W-1:0] mode;
  logic [W-1:0] pol;
  logic [W-1:0] connect;
  logic [W-1:0] event_hit;
  modport det (input pin_sync, input mode, input pol, input connect, output event_hit);
  modport ctl (output pin_sync, output mode, output pol, output connect, input event_hit);
endinterface : gpp_evt_if
`default_nettype wire

// File: core/gpp_sync.sv
// Two-stage synchroniser for the pin inputs
`default_nettype none
module gpp_sync #(
  parameter int unsigned W = 32
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule : gpp_sync
`default_nettype wire

// File: core/gpp_detect.sv
// Per-pin level and edge event detection
`default_nettype none
module gpp_detect #(
  parameter int unsigned W = 32
) (
  input  wire logic clock,
  input  wire logic rst_n,
  gpp_evt_if.det    evt
);
  logic [W-1:0] prev_q;

  // Edge history follows only connected pads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= evt.pin_sync & evt.connect;
    end
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!evt.connect[i]) begin
        evt.event_hit[i] = 1'b0;
      end else if (evt.mode[i]) begin
        evt.event_hit[i] = evt.pol[i] ? (evt.pin_sync[i] & ~prev_q[i])
                                      : (~evt.pin_sync[i] & prev_q[i]);
      end else begin
        evt.event_hit[i] = ~(evt.pin_sync[i] ^ evt.pol[i]);
      end
    end
  end
endmodule : gpp_detect
`default_nettype wire

// File: core/gpp_port.sv
// GPIO port top: AXI4-Lite register bank, pin drive and interrupt flags
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned PINS = GPP_PINS
) (
  input  wire logic            clock,
  input  wire logic            rst_b,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output var  logic            s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output var  logic            s_axi_wready,
  output var  logic [1:0]      s_axi_bresp,
  output var  logic            s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output var  logic            s_axi_arready,
  output var  logic [31:0]     s_axi_rdata,
  output var  logic [1:0]      s_axi_rresp,
  output var  logic            s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [PINS-1:0] pin_in,
  output var  logic [PINS-1:0] pin_out,
  output var  logic [PINS-1:0] pin_oe_b,
  output var  logic [PINS-1:0] af_select,
  output var  logic            irq_q
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // One 32-bit register word per port, so the pin count is fixed
  if (PINS != 32) begin : g_pin_check
    $error("gpp_port supports exactly 32 pins");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_m_q, rst_n;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] af_q, oe_q, out_q, mode_q, pol_q, incon_q, ie_q, pend_q;
  logic [31:0] pin_sync;

  gpp_evt_if #(.W(32)) evt ();

  gpp_sync #(.W(32)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_q   (pin_sync)
  );

  assign evt.pin_sync = pin_sync;
  assign evt.mode     = mode_q;
  assign evt.pol      = pol_q;
  assign evt.connect  = incon_q;

  gpp_detect #(.W(32)) u_det (
    .clock (clock),
    .rst_n (rst_n),
    .evt   (evt)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        aw_held_q, w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic [31:0] wmask;
  logic [31:0] wval;

  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wval  = wdata_q & wmask;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // Refuse new writes while a response waits: one write at a time
      s_axi_awready <= !aw_held_q && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
    end
  end

  function automatic logic mapped_wr(input logic [7:0] a);
    case (a)
      OFF_AF_SEL, OFF_AF_SET, OFF_AF_CLR, OFF_OE, OFF_OE_SET, OFF_OE_CLR,
      OFF_OUT, OFF_OUT_SET, OFF_OUT_CLR, OFF_MODE, OFF_POL, OFF_INCON,
      OFF_IE, OFF_IE_SET, OFF_IE_CLR, OFF_PEND_CLR, OFF_IN, OFF_PEND,
      OFF_WAKE: mapped_wr = 1'b1;
      default:  mapped_wr = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped_wr(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Direct write replaces only strobed lanes; set/clear act on written ones
  function automatic logic [31:0] upd(input logic [31:0] cur, input logic [7:0] base,
                                      input logic [7:0] set_a, input logic [7:0] clr_a,
                                      input logic [7:0] a, input logic [31:0] v,
                                      input logic [31:0] m);
    upd = cur;
    if (a == base) upd = (cur & ~m) | v;
    else if (a == set_a) upd = cur | v;
    else if (a == clr_a) upd = cur & ~v;
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      af_q <= RST_AF_SEL;
    end else if (wr_go) begin
      af_q <= upd(af_q, OFF_AF_SEL, OFF_AF_SET, OFF_AF_CLR, awaddr_q, wval, wmask);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= RST_ZERO;
    end else if (wr_go) begin
      oe_q <= upd(oe_q, OFF_OE, OFF_OE_SET, OFF_OE_CLR, awaddr_q, wval, wmask);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= RST_ZERO;
    end else if (wr_go) begin
      out_q <= upd(out_q, OFF_OUT, OFF_OUT_SET, OFF_OUT_CLR, awaddr_q, wval, wmask);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= RST_ZERO;
    end else if (wr_go) begin
      ie_q <= upd(ie_q, OFF_IE, OFF_IE_SET, OFF_IE_CLR, awaddr_q, wval, wmask);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= RST_ZERO;
    end else if (wr_go && awaddr_q == OFF_MODE) begin
      mode_q <= (mode_q & ~wmask) | wval;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pol_q <= RST_ZERO;
    end else if (wr_go && awaddr_q == OFF_POL) begin
      pol_q <= (pol_q & ~wmask) | wval;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      incon_q <= RST_INCON;
    end else if (wr_go && awaddr_q == OFF_INCON) begin
      incon_q <= (incon_q & ~wmask) | wval;
    end
  end

  // ----------------------------------------------------------------
  // Pending flags and interrupt
  // ----------------------------------------------------------------
  logic [31:0] pend_clr;

  assign pend_clr = (wr_go && awaddr_q == OFF_PEND_CLR) ? wval : RST_ZERO;

  // ----------------------------------------------------------------
  // Detection arming
  // ----------------------------------------------------------------
  // Synchroniser shows zeros for two edges after reset; a low-level
  // trigger would otherwise flag every connected pin at start-up
  logic [1:0] arm_q;
  logic       armed;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 2'h0;
    end else begin
      arm_q <= {arm_q[0], 1'h1};
    end
  end

  assign armed = arm_q[1];

  // A new event beats a simultaneous clear; enable does not gate capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= RST_ZERO;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | (evt.event_hit & {32{armed}});
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(pend_q & ie_q);
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_out   <= RST_ZERO;
      pin_oe_b  <= 32'hFFFF_FFFF;
      af_select <= RST_AF_SEL;
    end else begin
      // Peripheral owns pins whose select bit is set
      pin_oe_b  <= ~(oe_q & ~af_q);
      pin_out   <= out_q & oe_q & ~af_q;
      af_select <= af_q;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_AF_SEL: rd_mux = af_q;
      OFF_OE:     rd_mux = oe_q;
      OFF_OUT:    rd_mux = out_q;
      OFF_IN:     rd_mux = pin_sync & incon_q;
      OFF_MODE:   rd_mux = mode_q;
      OFF_POL:    rd_mux = pol_q;
      OFF_INCON:  rd_mux = incon_q;
      OFF_IE:     rd_mux = ie_q;
      OFF_PEND:   rd_mux = pend_q;
      OFF_AF_SET, OFF_AF_CLR, OFF_OE_SET, OFF_OE_CLR, OFF_OUT_SET, OFF_OUT_CLR,
      OFF_IE_SET, OFF_IE_CLR, OFF_PEND_CLR, OFF_WAKE: rd_mux = RST_ZERO;
      default: begin
        rd_mux = RST_ZERO;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= RST_ZERO;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : gpp_port
`default_nettype wire

// File: verification/gpp_pin_model.sv
// External circuitry model sitting on the port pins
`default_nettype none
module gpp_pin_model #(
  parameter int unsigned PINS = 32
) (
  input  wire logic [PINS-1:0] pin_out,
  input  wire logic [PINS-1:0] pin_oe_b,
  input  wire logic [PINS-1:0] ext_lvl,
  output var  logic [PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Device driver wins where enabled; elsewhere the outside level shows
  assign pin_in = (pin_out & ~pin_oe_b) | (ext_lvl & pin_oe_b);
endmodule : gpp_pin_model
`default_nettype wire

// File: verification/gpp_port_sva.sv
// Bus and pin-drive assertions for the GPIO port block
`default_nettype none
module gpp_port_sva #(
  parameter int unsigned PINS = 32
) (
  input wire logic            clock,
  input wire logic            rst_b,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_b,
  input wire logic [PINS-1:0] af_select,
  input wire logic            irq_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Handshake steps
  // ----------------------------------------
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_take_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp})) else $error("read data dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read response");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  // ----------------------------------------
  // Pin drive and interrupt line
  // ----------------------------------------
  drive_gate_a: assert property ((pin_out & pin_oe_b) == '0)
    else $error("level shown on undriven pin");
  af_release_a: assert property ((af_select & ~pin_oe_b) == '0)
    else $error("alternate pin driven by port");
  reset_val_a: assert property ($rose(rst_b) |->
    af_select == '1 && pin_oe_b == '1 && pin_out == '0 && !irq_q)
    else $error("pin outputs wrong after reset");
  irq_drop_a: assert property ($fell(irq_q) |-> s_axi_bvalid ||
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("interrupt fell without write");
endmodule : gpp_port_sva
`default_nettype wire

// File: verification/test_gpio_port_pin_control.sv
// Self-checking bench for the GPIO port block
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module test_gpio_port_pin_control
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 0;
  logic        rst_b = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_q;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] pin_in, pin_out, pin_oe_b, af_select;
  logic [31:0] ext_lvl = 32'hFFFF_FFFF;
  int          err_total = 0, total_checks = 0;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  bit          slow = 0;
  // Pads float high, so only connected pads read back as ones
  localparam logic [39:0] RST_TAB [11] = '{{OFF_AF_SEL, RST_AF_SEL}, {OFF_OE, RST_ZERO},
    {OFF_OUT, RST_ZERO}, {OFF_IN, RST_INCON}, {OFF_POL, RST_ZERO}, {OFF_INCON, RST_INCON},
    {OFF_IE, RST_ZERO}, {OFF_AF_SET, RST_ZERO}, {OFF_WAKE, RST_ZERO}, {OFF_PEND, RST_ZERO},
    {8'h50, RST_ZERO}};
  always #12.5 clock = ~clock;
  gpp_port dut_u (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_b, .af_select, .irq_q);
  gpp_pin_model pins_u (.pin_out, .pin_oe_b, .ext_lvl, .pin_in);
  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  task automatic take(input bit r);
    do @(posedge clock); while (!(r ? s_axi_rvalid : s_axi_bvalid));
    // Slow mode leaves the response waiting to exercise its hold
    if (slow) begin
      repeat (2) @(posedge clock);
      if (r) s_axi_rready <= 1;
      else s_axi_bready <= 1;
      @(posedge clock);
    end
    if (r) s_axi_rready <= 0;
    else s_axi_bready <= 0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    wr_q.push_back(a > OFF_WAKE ? RESP_SLVERR : RESP_OKAY);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= !slow;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 0;
      end
    end
    take(0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back({a > OFF_WAKE ? RESP_SLVERR : RESP_OKAY, e});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= !slow;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    take(1);
  endtask
  always @(posedge clock) begin
    logic [33:0] n;
    if (s_axi_rvalid && s_axi_rready) begin
      n = rd_q.pop_front();
      `CHK("read", n, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n = {32'h0000_0000, wr_q.pop_front()};
      `CHK("bresp", n[1:0], s_axi_bresp)
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] v, s, c, a, d, l;
    logic [7:0]  base [4];
    base = '{OFF_AF_SEL, OFF_OE, OFF_OUT, OFF_IE};
    void'($urandom(59359));
    repeat (8) @(posedge clock);
    rst_b <= 1;
    repeat (4) @(posedge clock);
    foreach (RST_TAB[i]) begin
      slow = i[0];
      rd(RST_TAB[i][39:32], RST_TAB[i][31:0]);
    end
    // Responses wait from here on, to exercise their hold
    slow = 1;
    wr(8'h50, 32'hFFFF_FFFF);
    // All 32 pins exist, so random fills touch no absent pin
    foreach (base[i]) begin
      v = $urandom();
      s = $urandom();
      c = $urandom();
      wr(base[i], v);
      wr(base[i] + 8'h04, s);
      rd(base[i], v | s);
      wr(base[i] + 8'h08, c);
      rd(base[i], (v | s) & ~c);
    end
    a = $urandom();
    d = $urandom();
    l = $urandom();
    ext_lvl <= $urandom();
    wr(OFF_AF_SEL, a);
    wr(OFF_OE, d);
    wr(OFF_OUT, l);
    wr(OFF_INCON, 32'hFFFF_FFFF);
    d = d & ~a;
    `CHK("pin_oe_b", ~d, pin_oe_b)
    `CHK("pin_out", l & d, pin_out)
    `CHK("af_select", a, af_select)
    rd(OFF_IN, (l & d) | (ext_lvl & ~d));
    wr(OFF_OE, 32'h0000_0000);
    ext_lvl <= 32'h0000_0000;
    wr(OFF_IE, 32'h0000_0000);
    wr(OFF_MODE, 32'h0000_000C);
    wr(OFF_POL, 32'h0000_000A);
    wr(OFF_INCON, 32'h0000_000F);
    wr(OFF_PEND_CLR, 32'hFFFF_FFFF);
    rd(OFF_PEND, 32'h0000_0001);
    ext_lvl <= 32'h0000_000E;
    repeat (6) @(posedge clock);
    rd(OFF_PEND, 32'h0000_000B);
    wr(OFF_PEND_CLR, 32'hFFFF_FFFF);
    rd(OFF_PEND, 32'h0000_0003);
    ext_lvl <= 32'h0000_0000;
    repeat (6) @(posedge clock);
    rd(OFF_PEND, 32'h0000_0007);
    wr(OFF_PEND_CLR, 32'h0000_0002);
    rd(OFF_PEND, 32'h0000_0005);
    `CHK("irq_q", 1'b0, irq_q)
    wr(OFF_IE_SET, 32'h0000_0004);
    repeat (2) @(posedge clock);
    `CHK("irq_q", 1'b1, irq_q)
    wr(OFF_IE_CLR, 32'h0000_0004);
    repeat (2) @(posedge clock);
    `CHK("irq_q", 1'b0, irq_q)
    rd(OFF_PEND, 32'h0000_0005);
    wr(OFF_IE_SET, 32'h0000_0004);
    wr(OFF_PEND_CLR, 32'h0000_0004);
    repeat (2) @(posedge clock);
    `CHK("irq_q", 1'b0, irq_q)
    end_sim();
  end
endmodule : test_gpio_port_pin_control
bind gpp_port gpp_port_sva #(.PINS(PINS)) sva_u (.clock, .rst_b, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .pin_out, .pin_oe_b, .af_select, .irq_q);
`default_nettype wire
